// *** design/pin_ctl_consts.svh ***
// Purpose: Offsets, field positions, reset values and codes of the two-pin control block.
// Assumes: Included by bare name from the package and the design modules.
// Notes: Holds definitions only.
`ifndef PIN_CTL_CONSTS_SVH
`define PIN_CTL_CONSTS_SVH

// Register byte offsets on the AXI4-Lite bus.
`define OFS_PIN_A_CONTROL 8'h58
`define OFS_PIN_B_CONTROL 8'h5C
`define OFS_IRQ_STATUS 8'h80
`define OFS_IRQ_MASK 8'h84

// Field positions inside a pin control word.
`define BIT_IRQ_FORWARD_MASK 25
`define TRIG_HI 23
`define TRIG_LO 21
`define BIT_PIN_IRQ_ENABLE 20
`define DRV_HI 14
`define DRV_LO 12
`define BIT_STRONG_PULLUP 11
`define BIT_WEAK_PULLDOWN 9
`define BIT_PULLUP_8 8
`define BIT_INPUT_PATH 7
`define BIT_OUTPUT_DRIVER 6
`define BIT_SCHMITT 5
`define BIT_ANALOG_SEL 4
`define FUNC_HI 3
`define FUNC_LO 0

// Writable bits of a control word and its reset value.
`define CTL_WRITE_MASK 32'h02F0_7BFF
`define CTL_RESET 32'h0000_1001

// Trigger mode codes.
`define TRIG_RISE 3'h0
`define TRIG_FALL 3'h1
`define TRIG_BOTH 3'h2
`define TRIG_HIGH 3'h3
`define TRIG_LOW 3'h4

// Highest legal function code, and the plain general-purpose code.
`define FUNC_MAX 4'h8
`define FUNC_GPIO 4'h1
`define NUM_FUNC 9

// Bus responses.
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// *** design/pin_ctl_pkg.sv ***
// Purpose: Types shared by the two-pin control block.
// Assumes: Constants come from the header.
// Notes: No imports are used anywhere; names are written in full.
`include "pin_ctl_consts.svh"
package pin_ctl_pkg;
    typedef logic [2:0] trig_code_t;
    typedef logic [3:0] func_code_t;
    typedef logic [31:0] word_t;
    // Register selected by a bus address.
    typedef enum logic [2:0] {
        SEL_PIN_A,
        SEL_PIN_B,
        SEL_STATUS,
        SEL_MASK,
        SEL_NONE
    } reg_sel_t;
endpackage

// *** design/pin_sync.sv ***
// Purpose: Two-flop synchroniser for pad inputs.
// Assumes: Inputs are asynchronous to clk_i.
// Notes: The first stage feeds only the second stage.
`timescale 1ns/1ps
module pin_sync #(
    parameter int WIDTH = 2
) (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // Data.
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] stage1_ff;

    // Two stages in series; the second is the only reader of the first.
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            stage1_ff <= '0;
            sync_o <= '0;
        end else begin
            stage1_ff <= async_i;
            sync_o <= stage1_ff;
        end
    end
endmodule

// *** design/pin_trigger.sv ***
// Purpose: Detects the configured trigger condition on one synchronised pin.
// Assumes: level_i is already in the clk_i domain.
// Notes: Reserved mode codes never raise an event.
`timescale 1ns/1ps
`include "pin_ctl_consts.svh"
module pin_trigger (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // Pin level and mode.
    input wire logic level_i,
    input wire pin_ctl_pkg::trig_code_t mode_i,
    // Trigger condition seen this cycle.
    output logic event_o
);
    logic prev_ff;

    // Previous level for edge detection.
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            prev_ff <= 1'b0;
        end else begin
            prev_ff <= level_i;
        end
    end

    // Mode decode; level modes hold the event for as long as the level lasts.
    always_comb begin
        unique case (mode_i)
            `TRIG_RISE: event_o = level_i & ~prev_ff;
            `TRIG_FALL: event_o = ~level_i & prev_ff;
            `TRIG_BOTH: event_o = level_i ^ prev_ff;
            `TRIG_HIGH: event_o = level_i;
            `TRIG_LOW: event_o = ~level_i;
            default: event_o = 1'b0;
        endcase
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);

    a_rise_edge_only: assert property ((mode_i == `TRIG_RISE && event_o) |-> (level_i && !$past(level_i)))
        else $error("Rising trigger fired without a rising edge.");
    a_low_level_hold: assert property ((mode_i == `TRIG_LOW && !level_i) |-> event_o)
        else $error("Low level trigger missed a low pin.");
endmodule

// *** design/pin_control_irq_mux.sv ***
// Purpose: Control of two general-purpose pins: trigger detection, pending and forwarding of
//          interrupts, pad settings, analog channel select and a function multiplexer.
// Assumes: AXI4-Lite slave on clk_i at 10 MHz; pads and peripherals on the same chip.
// Notes: Pending bits sit in a status word cleared by writing one; a mask word gates irq_o.
`timescale 1ns/1ps
`include "pin_ctl_consts.svh"
module pin_control_irq_mux (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // AXI4-Lite write address and data.
    input wire logic [7:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    // AXI4-Lite write response.
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    // AXI4-Lite read.
    input wire logic [7:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    // Pads, index 0 is pin A and index 1 is pin B.
    input wire logic [1:0] pin_i,
    output logic [1:0] pin_o,
    output logic [1:0] pin_oe_o,
    // Pad settings.
    output logic [2:0] pad_drive_level_a_o,
    output logic [2:0] pad_drive_level_b_o,
    output logic [1:0] strong_pullup_en_o,
    output logic [1:0] weak_pulldown_en_o,
    output logic weak_pullup_en_o,
    output logic medium_pullup_en_o,
    output logic [1:0] input_path_en_o,
    output logic [1:0] schmitt_en_o,
    // Analog channel selects.
    output logic analog_channel_three_o,
    output logic analog_channel_four_o,
    // Peripheral side; peripheral outputs and enables one bit per function code, periph_in_o one bit per pin.
    input wire logic [8:0] periph_a_out_i,
    input wire logic [8:0] periph_a_oe_i,
    input wire logic [8:0] periph_b_out_i,
    input wire logic [8:0] periph_b_oe_i,
    output logic [1:0] periph_in_o,
    output logic [3:0] function_mux_sel_a_o,
    output logic [3:0] function_mux_sel_b_o,
    // Requests to the interrupt controller and the summary interrupt.
    output logic [1:0] irq_req_o,
    output logic irq_o
);
    // Selects the register at a byte address; used by both the read and the write path.
    function automatic pin_ctl_pkg::reg_sel_t reg_sel(input logic [7:0] addr);
        unique case (addr)
            `OFS_PIN_A_CONTROL: reg_sel = pin_ctl_pkg::SEL_PIN_A;
            `OFS_PIN_B_CONTROL: reg_sel = pin_ctl_pkg::SEL_PIN_B;
            `OFS_IRQ_STATUS: reg_sel = pin_ctl_pkg::SEL_STATUS;
            `OFS_IRQ_MASK: reg_sel = pin_ctl_pkg::SEL_MASK;
            default: reg_sel = pin_ctl_pkg::SEL_NONE;
        endcase
    endfunction

    // Merges write data into a word under the byte strobes.
    function automatic pin_ctl_pkg::word_t strb_merge(input pin_ctl_pkg::word_t old,
                                                      input pin_ctl_pkg::word_t data,
                                                      input logic [3:0] strb);
        pin_ctl_pkg::word_t res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = data[i*8 +: 8];
            end
        end
        strb_merge = res;
    endfunction

    pin_ctl_pkg::word_t ctl_ff [2];
    logic [1:0] status_ff;
    logic [1:0] mask_ff;
    logic [7:0] awaddr_ff;
    logic aw_have_ff;
    pin_ctl_pkg::word_t wdata_ff;
    logic [3:0] wstrb_ff;
    logic w_have_ff;
    logic wr_fire;
    pin_ctl_pkg::reg_sel_t wr_sel;
    logic [1:0] pin_sync;
    logic [1:0] trig_event;
    logic [1:0] status_clr;
    logic [8:0] fn_out [2];
    logic [8:0] fn_oe [2];

    // A write is carried out once address and data are both held and no response is pending.
    assign wr_fire = aw_have_ff & w_have_ff & ~s_axi_bvalid_o;
    assign wr_sel = reg_sel(awaddr_ff);
    assign fn_out[0] = periph_a_out_i;
    assign fn_out[1] = periph_b_out_i;
    assign fn_oe[0] = periph_a_oe_i;
    assign fn_oe[1] = periph_b_oe_i;

    // Pad inputs cross into the clock domain before any logic looks at them.
    pin_sync #(
        .WIDTH(2)
    ) u_sync (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .async_i(pin_i),
        .sync_o(pin_sync)
    );

    // Write address and data are taken independently, in either order.
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            aw_have_ff <= 1'b0;
            awaddr_ff <= 8'h00;
            s_axi_awready_o <= 1'b1;
        end else if (s_axi_awvalid_i && s_axi_awready_o) begin
            aw_have_ff <= 1'b1;
            awaddr_ff <= s_axi_awaddr_i;
            s_axi_awready_o <= 1'b0;
        end else if (s_axi_bvalid_o && s_axi_bready_i) begin
            aw_have_ff <= 1'b0;
            s_axi_awready_o <= 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            w_have_ff <= 1'b0;
            wdata_ff <= 32'h0000_0000;
            wstrb_ff <= 4'h0;
            s_axi_wready_o <= 1'b1;
        end else if (s_axi_wvalid_i && s_axi_wready_o) begin
            w_have_ff <= 1'b1;
            wdata_ff <= s_axi_wdata_i;
            wstrb_ff <= s_axi_wstrb_i;
            s_axi_wready_o <= 1'b0;
        end else if (s_axi_bvalid_o && s_axi_bready_i) begin
            w_have_ff <= 1'b0;
            s_axi_wready_o <= 1'b1;
        end
    end

    // Write response one cycle after both halves are held; unmapped addresses answer SLVERR.
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            s_axi_bvalid_o <= 1'b0;
            s_axi_bresp_o <= `RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid_o <= 1'b1;
            s_axi_bresp_o <= (wr_sel == pin_ctl_pkg::SEL_NONE) ? `RESP_SLVERR : `RESP_OKAY;
        end else if (s_axi_bready_i) begin
            s_axi_bvalid_o <= 1'b0;
        end
    end

    // Read path: address taken, data registered, held until rready.
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            s_axi_arready_o <= 1'b1;
            s_axi_rvalid_o <= 1'b0;
            s_axi_rdata_o <= 32'h0000_0000;
            s_axi_rresp_o <= `RESP_OKAY;
        end else if (s_axi_arvalid_i && s_axi_arready_o) begin
            s_axi_arready_o <= 1'b0;
            s_axi_rvalid_o <= 1'b1;
            s_axi_rresp_o <= `RESP_OKAY;
            unique case (reg_sel(s_axi_araddr_i))
                pin_ctl_pkg::SEL_PIN_A: s_axi_rdata_o <= ctl_ff[0];
                pin_ctl_pkg::SEL_PIN_B: s_axi_rdata_o <= ctl_ff[1];
                pin_ctl_pkg::SEL_STATUS: s_axi_rdata_o <= {30'h0000_0000, status_ff};
                pin_ctl_pkg::SEL_MASK: s_axi_rdata_o <= {30'h0000_0000, mask_ff};
                pin_ctl_pkg::SEL_NONE: begin
                    s_axi_rdata_o <= 32'h0000_0000;
                    s_axi_rresp_o <= `RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rvalid_o && s_axi_rready_i) begin
            s_axi_rvalid_o <= 1'b0;
            s_axi_arready_o <= 1'b1;
        end
    end

    // Interrupt mask word, one bit per pin.
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            mask_ff <= 2'h0;
        end else if (wr_fire && wr_sel == pin_ctl_pkg::SEL_MASK && wstrb_ff[0]) begin
            mask_ff <= wdata_ff[1:0];
        end
    end

    // A status bit is cleared by writing a one to it.
    assign status_clr = (wr_fire && wr_sel == pin_ctl_pkg::SEL_STATUS && wstrb_ff[0]) ? wdata_ff[1:0] : 2'h0;

    // Per-pin control word, trigger detection, pending state and pad multiplexer.
    for (genvar p = 0; p < 2; p++) begin : g_pin
        logic [3:0] func;
        logic digital_ok;
        assign func = ctl_ff[p][`FUNC_HI:`FUNC_LO];
        // Reserved function codes leave the pad undriven.
        assign digital_ok = ~ctl_ff[p][`BIT_ANALOG_SEL] & (func <= `FUNC_MAX);

        // Only documented bits store; reserved bits stay zero.
        always_ff @(posedge clk_i) begin
            if (sys_rst_i) begin
                ctl_ff[p] <= `CTL_RESET;
            end else if (wr_fire && wr_sel == ((p == 0) ? pin_ctl_pkg::SEL_PIN_A : pin_ctl_pkg::SEL_PIN_B)) begin
                ctl_ff[p] <= strb_merge(ctl_ff[p], wdata_ff, wstrb_ff) & `CTL_WRITE_MASK;
            end
        end

        pin_trigger u_trig (
            .clk_i(clk_i),
            .sys_rst_i(sys_rst_i),
            .level_i(pin_sync[p]),
            .mode_i(ctl_ff[p][`TRIG_HI:`TRIG_LO]),
            .event_o(trig_event[p])
        );

        // Pending is set only while enabled; a set in the clearing cycle wins.
        always_ff @(posedge clk_i) begin
            if (sys_rst_i) begin
                status_ff[p] <= 1'b0;
            end else if (trig_event[p] && ctl_ff[p][`BIT_PIN_IRQ_ENABLE]) begin
                status_ff[p] <= 1'b1;
            end else if (status_clr[p]) begin
                status_ff[p] <= 1'b0;
            end
        end

        // Request to the interrupt controller: pending, enabled and forwarded.
        always_ff @(posedge clk_i) begin
            if (sys_rst_i) begin
                irq_req_o[p] <= 1'b0;
            end else begin
                irq_req_o[p] <= status_ff[p] & ctl_ff[p][`BIT_PIN_IRQ_ENABLE]
                                & ctl_ff[p][`BIT_IRQ_FORWARD_MASK];
            end
        end

        // Pad drive follows the selected function while the output driver is on.
        always_ff @(posedge clk_i) begin
            if (sys_rst_i) begin
                pin_o[p] <= 1'b0;
                pin_oe_o[p] <= 1'b0;
                periph_in_o[p] <= 1'b0;
            end else begin
                pin_o[p] <= digital_ok ? fn_out[p][func] : 1'b0;
                pin_oe_o[p] <= digital_ok & ctl_ff[p][`BIT_OUTPUT_DRIVER] & fn_oe[p][func];
                periph_in_o[p] <= digital_ok & ctl_ff[p][`BIT_INPUT_PATH] & pin_sync[p];
            end
        end
    end

    // Pad settings and selects, each a field of the control word.
    assign pad_drive_level_a_o = ctl_ff[0][`DRV_HI:`DRV_LO];
    assign pad_drive_level_b_o = ctl_ff[1][`DRV_HI:`DRV_LO];
    assign strong_pullup_en_o = {ctl_ff[1][`BIT_STRONG_PULLUP], ctl_ff[0][`BIT_STRONG_PULLUP]};
    assign weak_pulldown_en_o = {ctl_ff[1][`BIT_WEAK_PULLDOWN], ctl_ff[0][`BIT_WEAK_PULLDOWN]};
    assign weak_pullup_en_o = ctl_ff[0][`BIT_PULLUP_8];
    assign medium_pullup_en_o = ctl_ff[1][`BIT_PULLUP_8];
    assign input_path_en_o = {ctl_ff[1][`BIT_INPUT_PATH], ctl_ff[0][`BIT_INPUT_PATH]};
    assign schmitt_en_o = {ctl_ff[1][`BIT_SCHMITT], ctl_ff[0][`BIT_SCHMITT]};
    // Each channel is owned by one pin here; sharing with other pins is software's duty.
    assign analog_channel_three_o = ctl_ff[0][`BIT_ANALOG_SEL];
    assign analog_channel_four_o = ctl_ff[1][`BIT_ANALOG_SEL];
    assign function_mux_sel_a_o = ctl_ff[0][`FUNC_HI:`FUNC_LO];
    assign function_mux_sel_b_o = ctl_ff[1][`FUNC_HI:`FUNC_LO];

    // Summary interrupt, high while an unmasked pending bit is set.
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(status_ff & mask_ff);
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);

    sequence s_both_held;
        aw_have_ff && w_have_ff && !s_axi_bvalid_o;
    endsequence
    sequence s_resp_out;
        s_axi_bvalid_o && !s_axi_awready_o && !s_axi_wready_o;
    endsequence

    a_write_resp_follows: assert property (s_both_held |=> s_resp_out)
        else $error("Write response did not follow both halves.");
    a_irq_disabled_quiet: assert property ((!ctl_ff[0][20] && !status_ff[0]) |=> !status_ff[0])
        else $error("Pin A pending set while disabled.");
    a_pending_on_event: assert property ((ctl_ff[1][20] && trig_event[1]) |=> status_ff[1])
        else $error("Pin B trigger did not set pending.");
    a_forward_gate: assert property ((!ctl_ff[0][25] || !status_ff[0]) |=> !irq_req_o[0])
        else $error("Request sent without forward mask or pending.");
    a_forward_pass: assert property ((ctl_ff[1][25] && ctl_ff[1][20] && status_ff[1]) |=> irq_req_o[1])
        else $error("Forwarded pending did not reach the controller.");
    a_drive_reset: assert property ($fell(sys_rst_i) |->
        (pad_drive_level_a_o == 3'h1 && function_mux_sel_b_o == 4'h1))
        else $error("Drive level or function not at reset value.");
    a_analog_undriven: assert property (ctl_ff[0][4] |=> !pin_oe_o[0])
        else $error("Pad driven while in analog use.");
    a_reserved_func: assert property ((ctl_ff[1][3:0] > 4'h8) |=> !pin_oe_o[1])
        else $error("Pad driven with a reserved function code.");
    a_summary_irq: assert property (|(status_ff & mask_ff) |=> irq_o)
        else $error("Summary interrupt missed an unmasked pending bit.");
endmodule

// *** tb/periph_model.sv ***
// Purpose: Stand-in for the on-chip peripherals that feed the function multiplexer.
// Assumes: Shares clk_i and sys_rst_i with the block.
// Notes: Outputs change every cycle, so a stale multiplexer path cannot hide.
`timescale 1ns/1ps
module periph_model (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // Peripheral outputs and enables, one bit per function code.
    output logic [8:0] a_out_o,
    output logic [8:0] a_oe_o,
    output logic [8:0] b_out_o,
    output logic [8:0] b_oe_o
);
    logic [17:0] pat_ff;

    // A shift register gives a new pattern on every clock.
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            pat_ff <= 18'h2B5A3;
        end else begin
            pat_ff <= {pat_ff[16:0], pat_ff[17] ^ pat_ff[10]};
        end
    end

    // Enables are drawn from the same pattern, inverted.
    assign a_out_o = pat_ff[8:0];
    assign b_out_o = pat_ff[17:9];
    assign a_oe_o = ~pat_ff[17:9];
    assign b_oe_o = ~pat_ff[8:0];
endmodule

// *** tb/pin_control_irq_mux_test.sv ***
// Purpose: Self-checking bench for the two-pin control block.
// Assumes: AXI4-Lite master tasks; register offsets come from the shared header.
// Notes: Random words come from an LFSR with a fixed seed.
`timescale 1ns/1ps
`include "pin_ctl_consts.svh"
module pin_control_irq_mux_test;
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'hF;
    logic [1:0] pin_i = 2'h0;
    logic awready, wready, bvalid, arready, rvalid, wpu, mpu, an3, an4, irq;
    logic [1:0] bresp, rresp, pin_o, pin_oe, spu, wpd, ipe, sch, pin_in, irq_req;
    logic [31:0] rdata, d, v, seed;
    logic [2:0] drv_a, drv_b, t;
    logic [3:0] fa, fb;
    logic [1:0] r;
    logic [8:0] pa_out, pa_oe, pb_out, pb_oe;
    int bad_count = 0;
    int n_compared = 0;

    // Clock of 100 ns.
    always #50 clk_i = ~clk_i;

    pin_control_irq_mux uut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .s_axi_awaddr_i(awaddr),
        .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb),
        .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
        .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
        .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
        .pin_i(pin_i), .pin_o(pin_o), .pin_oe_o(pin_oe), .pad_drive_level_a_o(drv_a), .pad_drive_level_b_o(drv_b),
        .strong_pullup_en_o(spu), .weak_pulldown_en_o(wpd), .weak_pullup_en_o(wpu), .medium_pullup_en_o(mpu),
        .input_path_en_o(ipe), .schmitt_en_o(sch), .analog_channel_three_o(an3), .analog_channel_four_o(an4),
        .periph_a_out_i(pa_out), .periph_a_oe_i(pa_oe), .periph_b_out_i(pb_out), .periph_b_oe_i(pb_oe),
        .periph_in_o(pin_in), .function_mux_sel_a_o(fa), .function_mux_sel_b_o(fb), .irq_req_o(irq_req),
        .irq_o(irq));

    periph_model partner (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .a_out_o(pa_out), .a_oe_o(pa_oe),
        .b_out_o(pb_out), .b_oe_o(pb_oe));

    // Counts a comparison and reports a mismatch.
    task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
        n_compared++;
        if (g !== e) begin
            bad_count++;
            $display("wrong value at %0t: %s got %h expected %h", $time, m, g, e);
        end
    endtask

    // Prints the counts and the verdict, then stops.
    task automatic wrap_up;
        $display("compared %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Write: address and data offered together, each released when taken.
    task automatic wr(input logic [7:0] a, input logic [31:0] dw, input logic [3:0] s, output logic [1:0] rs);
        int n;
        logic ah, wh, bh;
        @(posedge clk_i);
        awaddr <= a;
        wdata <= dw;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        n = 0;
        bh = 1'b0;
        while (!bh && n < 50) begin
            @(negedge clk_i);
            ah = awvalid && awready;
            wh = wvalid && wready;
            bh = bvalid;
            rs = bresp;
            @(posedge clk_i);
            if (ah) awvalid <= 1'b0;
            if (wh) wvalid <= 1'b0;
            n++;
        end
        bready <= 1'b0;
        if (!bh) chk(32'h0, 32'h1, "write response missing");
    endtask

    // Read: rready held until rvalid is seen.
    task automatic rd(input logic [7:0] a, output logic [31:0] dr, output logic [1:0] rs);
        int n;
        logic ah, rh;
        @(posedge clk_i);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        n = 0;
        rh = 1'b0;
        while (!rh && n < 50) begin
            @(negedge clk_i);
            ah = arvalid && arready;
            rh = rvalid;
            dr = rdata;
            rs = rresp;
            @(posedge clk_i);
            if (ah) arvalid <= 1'b0;
            n++;
        end
        rready <= 1'b0;
        if (!rh) chk(32'h0, 32'h1, "read data missing");
    endtask

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // Pad outputs expected from a stored control word.
    function automatic logic [31:0] pads(input logic [31:0] w);
        return {19'h0, w[14:12], w[11], w[9], w[8], w[7], w[5], w[4], w[3:0]};
    endfunction

    // Pending after a rise, a hold-high with clear, then a fall: bit 0, 1, 2.
    function automatic logic [2:0] trig_exp(input int m);
        case (m)
            0: return 3'b001;
            1: return 3'b100;
            2: return 3'b101;
            3: return 3'b111;
            4: return 3'b101;
            default: return 3'b000;
        endcase
    endfunction

    // Watchdog far beyond the few hundred cycles the run needs.
    initial begin
        repeat (20000) @(posedge clk_i);
        bad_count++;
        wrap_up();
    end

    // Main sequence.
    initial begin
        seed = 32'hCA829A33;
        repeat (3) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        rd(`OFS_PIN_A_CONTROL, d, r);
        chk(d, 32'h00001001, "reset word a");
        rd(`OFS_PIN_B_CONTROL, d, r);
        chk(d, 32'h00001001, "reset word b");
        chk({spu, wpd, wpu, mpu, ipe, sch, an3, an4}, 32'h0, "reset pads");
        // Each pin owns its own analog channel, so random words never share one.
        for (int i = 0; i < 8; i++) begin
            seed = lfsr(seed);
            v = (i == 0) ? 32'hFFFFFFFF : seed;
            wr(`OFS_PIN_A_CONTROL, v, 4'hF, r);
            wr(`OFS_PIN_B_CONTROL, ~v, 4'hF, r);
            rd(`OFS_PIN_A_CONTROL, d, r);
            chk(d, v & 32'h02F07BFF, "word a");
            rd(`OFS_PIN_B_CONTROL, d, r);
            chk(d, ~v & 32'h02F07BFF, "word b");
            chk({19'h0, drv_a, spu[0], wpd[0], wpu, ipe[0], sch[0], an3, fa},
                pads(v), "pads a");
            chk({19'h0, drv_b, spu[1], wpd[1], mpu, ipe[1], sch[1], an4, fb}, pads(~v), "pads b");
            if (v[4] || v[3:0] > 4'h8) chk({31'h0, pin_oe[0]}, 32'h0, "drive in analog or reserved");
        end
        wr(`OFS_PIN_A_CONTROL, 32'h0, 4'hF, r);
        wr(`OFS_PIN_A_CONTROL, 32'hFFFFFFFF, 4'h2, r);
        rd(`OFS_PIN_A_CONTROL, d, r);
        chk(d, 32'h00007B00, "byte strobe");
        rd(8'h10, d, r);
        chk({d[29:0], r}, 32'h2, "unmapped read");
        wr(8'h20, 32'hFFFFFFFF, 4'hF, r);
        chk({30'h0, r}, 32'h2, "unmapped write");
        // Every trigger code on pin A; pin B armed in high mode but not enabled.
        wr(`OFS_IRQ_MASK, 32'h3, 4'hF, r);
        for (int m = 0; m < 6; m++) begin
            t = trig_exp(m);
            pin_i <= 2'b00;
            wr(`OFS_PIN_A_CONTROL, 32'h02101001 | (32'(m) << 21), 4'hF, r);
            wr(`OFS_PIN_B_CONTROL, 32'h02601001, 4'hF, r);
            repeat (4) @(posedge clk_i);
            wr(`OFS_IRQ_STATUS, 32'h3, 4'hF, r);
            pin_i <= 2'b11;
            repeat (6) @(posedge clk_i);
            rd(`OFS_IRQ_STATUS, d, r);
            chk(d, {31'h0, t[0]}, "pending after rise");
            chk({29'h0, irq, irq_req}, {29'h0, t[0], 1'b0, t[0]}, "requests after rise");
            wr(`OFS_IRQ_STATUS, 32'h3, 4'hF, r);
            repeat (4) @(posedge clk_i);
            rd(`OFS_IRQ_STATUS, d, r);
            chk(d, {31'h0, t[1]}, "pending while high");
            pin_i <= 2'b00;
            repeat (6) @(posedge clk_i);
            rd(`OFS_IRQ_STATUS, d, r);
            chk(d, {31'h0, t[2]}, "pending after fall");
        end
        // Forward bit clear: pending and summary rise, no request.
        wr(`OFS_PIN_A_CONTROL, 32'h00701001, 4'hF, r);
        pin_i <= 2'b01;
        repeat (6) @(posedge clk_i);
        chk({29'h0, irq, irq_req}, 32'h4, "forward blocked");
        wr(`OFS_IRQ_MASK, 32'h0, 4'hF, r);
        repeat (3) @(posedge clk_i);
        chk({31'h0, irq}, 32'h0, "summary masked");
        // Pin A on function 5 with both paths on follows that peripheral one edge late; pin B in analog use.
        pin_i <= 2'b11;
        wr(`OFS_PIN_A_CONTROL, 32'h000010C5, 4'hF, r);
        wr(`OFS_PIN_B_CONTROL, 32'h000010D5, 4'hF, r);
        for (int k = 0; k < 8; k++) begin
            @(negedge clk_i);
            v = {30'h0, pa_out[5], pa_oe[5]};
            @(negedge clk_i);
            chk({30'h0, pin_o[0], pin_oe[0]}, v, "pad a follows function");
            chk({28'h0, pin_oe[1], pin_o[1], pin_in}, 32'h1, "pad b analog and inputs");
        end
        wrap_up();
    end
endmodule
